// file: sim/pin_mux_timestamp_capture_bench.sv
// pin_mux_timestamp_capture_bench: self-checking bench for pmtc_top
`timescale 1ns/10ps
module pin_mux_timestamp_capture_bench
	import pmtc_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rvld, ix, iy;
	logic [8:0] addr = 9'h000;
	logic [15:0] wdat = 16'h0000, rdat, wrem = 16'h0000, er = 16'h0000;
	logic [1:0] pin_in, pout, poe, ppu, ppd, pien, slew, drv;
	logic [1:0] ext = 2'h0, ext_en = 2'h0;
	logic fth = 0, fuf = 0, fof = 0, led1 = 0, led2 = 0, olf = 0, ohf = 0;
	logic [11:0] act = 0, lvl = 0, led = 0, mdp = 0, dat = 0;
	logic [31:0] tmr = 32'h0000_0000, el = 32'h0000_0000;
	int num_errors = 0, checks_done = 0, cycles = 0;
	logic [8:0] ra [12] = '{9'h00B, 9'h014, 9'h015, 9'h022, 9'h023, 9'h026,
		9'h011, 9'h012, 9'h013, 9'h025, 9'h00F, 9'h030};
	logic [15:0] rm [6] = '{16'h8000, 16'hE000, 16'hE000, 16'hF03F,
		16'hFFFF, 16'h01F0};
	logic [3:0] sc [5] = '{4'h0, 4'h7, 4'h8, 4'h4, 4'h3};

	pmtc_top u_pmtc_top (.i_sys_clk(clk), .i_reset_n(rst_n),
		.i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_wdata(wdat), .o_reg_rdata(rdat), .o_reg_rvalid(rvld),
		.i_pin_in(pin_in), .o_pin_out(pout), .o_pin_oe(poe),
		.o_pin_pull_up(ppu), .o_pin_pull_dn(ppd), .o_pin_in_en(pien),
		.o_pin_slew(slew), .o_pin_drive(drv), .o_int_x(ix), .o_int_y(iy),
		.i_fifo_threshold(fth), .i_fifo_underflow(fuf),
		.i_fifo_overflow(fof), .i_led1_amp(led1), .i_led2_amp(led2),
		.i_osc_lf(olf), .i_osc_hf(ohf), .i_slot_active(act),
		.i_slot_level(lvl), .i_slot_led(led), .i_slot_mod(mdp),
		.i_slot_data(dat), .i_timer_count(tmr), .i_wake_remaining(wrem));

	pmtc_pad_model u_pmtc_pad_model (.i_sys_clk(clk), .i_reset_n(rst_n),
		.i_pin_out(pout), .i_pin_oe(poe), .i_pull_up(ppu),
		.i_pull_dn(ppd), .i_ext_level(ext), .i_ext_en(ext_en),
		.o_level(pin_in));

	// 25 MHz clock
	initial begin
		forever #20 clk = ~clk;
	end

	// hang guard: the whole run needs well under this many cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("counts: checks=%0d errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// inputs move 2 ns after the edge so sampling never races
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic reg_wr(input logic [8:0] a, input logic [15:0] d);
		tick(1);
		addr = a;
		wdat = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
	endtask

	// read answer stands for exactly the cycle after the strobe
	task automatic reg_rd(input logic [8:0] a, input logic [15:0] exp);
		tick(1);
		addr = a;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		check({15'h0000, rvld}, 16'h0001);
		check(rdat, exp);
	endtask

	// reference level of a source code; sleep level is kept at 1
	function automatic logic exp_src(input logic [7:0] c);
		int i;
		i = int'(c[3:0]);
		if (c == 8'h01) return 1'b1;
		if (c == 8'h08) return led1;
		if (c == 8'h09) return led2;
		if (c == 8'h0C) return led1 | led2;
		if (c == 8'h10) return (|act) ? |(act & lvl) : 1'b1;
		if (c == 8'h16) return olf;
		if (c == 8'h17) return ohf;
		if (c == 8'h3F) return |(led & act);
		if (c == 8'h4F) return |(mdp & act);
		if (c == 8'h5F) return |dat;
		if (c[7:4] == 4'h2 && i < 12) return act[i];
		if (c[7:4] == 4'h3 && i >= 1 && i <= 12) return led[i - 1];
		if (c[7:4] == 4'h4 && i < 12) return mdp[i];
		if (c[7:4] == 4'h5 && i < 12) return dat[i];
		return 1'b0;
	endfunction

	// one stamp case: a wrong-way edge, then a qualifying one, twice
	task automatic stamp_case(input logic [3:0] s);
		logic [1:0] p;
		logic inv;
		p = s[3:2];
		inv = s[1];
		reg_wr(PMTC_OFS_ARM, 16'h0000);
		reg_wr(PMTC_OFS_STAMP_CTL, {7'h00, 1'b0, inv, s[0], p, 4'h0});
		ext[p[0]] = ~inv;
		reg_wr(PMTC_OFS_ARM, 16'h8000);
		for (int k = 0; k < 2; k++) begin
			ext[p[0]] = inv;
			tmr = $urandom;
			tick(3);
			tmr = $urandom;
			wrem = 16'($urandom);
			if (p < 2 && (k == 0 || s[0])) begin
				el = tmr;
				er = wrem;
			end
			ext[p[0]] = ~inv;
			tick(3);
		end
		reg_rd(PMTC_OFS_STAMP_LO, el[15:0]);
		reg_rd(PMTC_OFS_STAMP_HI, el[31:16]);
		reg_rd(PMTC_OFS_WAKE_REM, er);
		reg_rd(PMTC_OFS_ARM, (p < 2 && !s[0]) ? 16'h0 : 16'h8000);
	endtask

	initial begin
		logic [15:0] d;
		logic [2:0] ex, ey, st;
		logic [1:0] md2;
		logic e, lv, oe;
		void'($urandom(32'h62DC));
		repeat (4) @(posedge clk);
		#2;
		rst_n = 1'b1;
		// read-only and unmapped writes are dropped, the SYS write is a soft reset, all read 0
		for (int k = 6; k < 12; k++) reg_wr(ra[k], 16'hFFFF);
		for (int k = 0; k < 12; k++) reg_rd(ra[k], 16'h0000);
		$display("test reset_values done");
		for (int k = 0; k < 6; k++) begin
			d = 16'($urandom);
			reg_wr(ra[k], d);
			reg_rd(ra[k], d & rm[k]);
			if (k == 3) check({12'h0, slew, drv}, {12'h0, d[15:12]});
		end
		reg_wr(PMTC_OFS_SYS, 16'h8000);
		reg_rd(PMTC_OFS_PIN_SEL, 16'h0000);
		reg_rd(PMTC_OFS_PIN_CFG, 16'h0000);
		$display("test register_access done");
		// every mode on both pins with both source levels
		for (int m = 0; m < 16; m++) begin
			reg_wr(PMTC_OFS_PIN_CFG, {10'h0, {2{3'(m >> 1)}}});
			reg_wr(PMTC_OFS_PIN_SEL, {2{7'h0, m[0]}});
			tick(2);
			lv = m[0] ^ m[1];
			md2 = 2'(m >> 2);
			oe = md2 == 1 || (md2 == 2 && !lv) || (md2 == 3 && lv);
			check({ppu, ppd, pien, poe}, {{2{md2 == 3}}, {2{md2 == 2}},
				{2{m > 1}}, {2{oe}}});
			if (oe) check({14'h0, pout}, {14'h0, {2{lv}}});
		end
		$display("test pin_modes done");
		// every source code except 0F and 18; pin 1 inverted; last pass is idle pattern
		reg_wr(PMTC_OFS_PIN_CFG, 16'h001A);
		reg_wr(PMTC_OFS_STAMP_CTL, 16'h0100);
		for (int c = 0; c <= 8'h60; c++) begin
			if (c == 8'h0F || c == 8'h18) continue;
			{act, lvl, led, mdp, dat} = 60'({$urandom, $urandom});
			if (c == 8'h60) act = 12'h000;
			{led1, led2, olf, ohf} = 4'($urandom);
			reg_wr(PMTC_OFS_PIN_SEL, {2{(c == 8'h60) ? 8'h10 : 8'(c)}});
			tick(3);
			e = exp_src((c == 8'h60) ? 8'h10 : 8'(c));
			check({15'h0, pout[0]}, {15'h0, e});
			check({15'h0, pout[1]}, {15'h0, ~e});
		end
		$display("test source_codes done");
		// divided taps count rising 32 MHz samples from a soft reset
		ohf = 1'b0;
		reg_wr(PMTC_OFS_SYS, 16'h8000);
		reg_wr(PMTC_OFS_PIN_CFG, 16'h001A);
		reg_wr(PMTC_OFS_PIN_SEL, {PMTC_SRC_HF_DIV32, PMTC_SRC_HF_DIV64});
		for (int n = 8; n <= 96; n += 8) begin
			repeat (8) begin
				ohf = 1'b1;
				tick(1);
				ohf = 1'b0;
				tick(1);
			end
			tick(3);
			check({15'h0, pout[0]}, {15'h0, n[5]});
			check({15'h0, pout[1]}, {15'h0, ~n[4]});
		end
		$display("test osc_dividers done");
		reg_wr(PMTC_OFS_PIN_CFG, 16'h0012);
		reg_wr(PMTC_OFS_PIN_SEL, 16'h0302);
		repeat (8) begin
			{ex, ey} = 6'($urandom);
			reg_wr(PMTC_OFS_IRQ_X, {ex, 13'h0});
			reg_wr(PMTC_OFS_IRQ_Y, {ey, 13'h0});
			st = 3'($urandom);
			{fth, fuf, fof} = st;
			tick(3);
			check({iy, ix}, {|(st & ey), |(st & ex)});
			check({pout}, {|(st & ey), |(st & ex)});
		end
		$display("test interrupts done");
		ext_en = 2'h3;
		for (int k = 0; k < 8; k++) begin
			reg_wr(PMTC_OFS_PIN_CFG, k[2] ? 16'h0009 : 16'h0001);
			ext = 2'($urandom);
			tick(2);
			reg_rd(PMTC_OFS_PIN_IN, {14'h0, ext & {k[2], 1'b1}});
		end
		$display("test readback done");
		for (int k = 0; k < 5; k++) stamp_case(sc[k]);
		$display("test time_stamp done");
		wrap_up();
	end
endmodule

// file: sim/pmtc_pad_model.sv
// pmtc_pad_model: pads and outside logic on the two pins
`timescale 1ns/10ps
module pmtc_pad_model (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [1:0] i_pin_out,
	input wire logic [1:0] i_pin_oe,
	input wire logic [1:0] i_pull_up,
	input wire logic [1:0] i_pull_dn,
	input wire logic [1:0] i_ext_level,
	input wire logic [1:0] i_ext_en,
	output logic [1:0] o_level
);
	logic [1:0] last_q;

	// device driver wins, then outside logic, then the pull resistors
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			if (i_pin_oe[k]) begin
				o_level[k] = i_pin_out[k];
			end else if (i_ext_en[k]) begin
				o_level[k] = i_ext_level[k];
			end else if (i_pull_up[k]) begin
				o_level[k] = 1'b1;
			end else if (i_pull_dn[k]) begin
				o_level[k] = 1'b0;
			end else begin
				o_level[k] = ~last_q[k]; // floating: never trust a held level
			end
		end
	end

	// last level, so that a floating pin keeps changing
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			last_q <= 2'h0;
		end else begin
			last_q <= o_level;
		end
	end
endmodule

// file: src/pmtc_pkg.sv
// pmtc_pkg: register map, field positions and source codes for the pin block
package pmtc_pkg;

	// register indices as seen on the register port
	localparam logic [8:0] PMTC_OFS_ARM = 9'h00B;
	localparam logic [8:0] PMTC_OFS_SYS = 9'h00F;
	localparam logic [8:0] PMTC_OFS_STAMP_LO = 9'h011;
	localparam logic [8:0] PMTC_OFS_STAMP_HI = 9'h012;
	localparam logic [8:0] PMTC_OFS_WAKE_REM = 9'h013;
	localparam logic [8:0] PMTC_OFS_IRQ_X = 9'h014;
	localparam logic [8:0] PMTC_OFS_IRQ_Y = 9'h015;
	localparam logic [8:0] PMTC_OFS_PIN_CFG = 9'h022;
	localparam logic [8:0] PMTC_OFS_PIN_SEL = 9'h023;
	localparam logic [8:0] PMTC_OFS_PIN_IN = 9'h025;
	localparam logic [8:0] PMTC_OFS_STAMP_CTL = 9'h026;

	// field positions
	localparam int PMTC_BIT_ARM = 15;
	localparam int PMTC_BIT_SW_RESET = 15;
	localparam int PMTC_BIT_EN_THRESH = 15;
	localparam int PMTC_BIT_EN_UFLOW = 14;
	localparam int PMTC_BIT_EN_OFLOW = 13;
	localparam int PMTC_BIT_SLEW_LO = 14;
	localparam int PMTC_BIT_DRV_LO = 12;
	localparam int PMTC_BIT_MODE1_LO = 3;
	localparam int PMTC_BIT_MODE0_LO = 0;
	localparam int PMTC_BIT_SEL1_LO = 8;
	localparam int PMTC_BIT_SEL0_LO = 0;
	localparam int PMTC_BIT_SLEEP_LVL = 8;
	localparam int PMTC_BIT_EDGE_INV = 7;
	localparam int PMTC_BIT_ALWAYS = 6;
	localparam int PMTC_BIT_PIN_SEL_LO = 4;

	// reset value shared by every register of the block
	localparam logic [15:0] PMTC_RST_REG = 16'h0000;

	// electrical modes of a pin
	typedef enum logic [2:0] {
		PMTC_MODE_OFF = 3'b000,
		PMTC_MODE_INPUT = 3'b001,
		PMTC_MODE_OUT = 3'b010,
		PMTC_MODE_OUT_INV = 3'b011,
		PMTC_MODE_PD = 3'b100,
		PMTC_MODE_PD_INV = 3'b101,
		PMTC_MODE_PU = 3'b110,
		PMTC_MODE_PU_INV = 3'b111
	} pmtc_mode_t;

	// stamp pin selector codes
	localparam logic [1:0] PMTC_STAMP_PIN0 = 2'h0;
	localparam logic [1:0] PMTC_STAMP_PIN1 = 2'h1;

	// output source codes
	localparam logic [7:0] PMTC_SRC_LOW = 8'h00;
	localparam logic [7:0] PMTC_SRC_HIGH = 8'h01;
	localparam logic [7:0] PMTC_SRC_INT_X = 8'h02;
	localparam logic [7:0] PMTC_SRC_INT_Y = 8'h03;
	localparam logic [7:0] PMTC_SRC_LED1_AMP = 8'h08;
	localparam logic [7:0] PMTC_SRC_LED2_AMP = 8'h09;
	localparam logic [7:0] PMTC_SRC_ANY_AMP = 8'h0C;
	localparam logic [7:0] PMTC_SRC_HF_DIV64 = 8'h0F;
	localparam logic [7:0] PMTC_SRC_PATTERN = 8'h10;
	localparam logic [7:0] PMTC_SRC_LF_OSC = 8'h16;
	localparam logic [7:0] PMTC_SRC_HF_OSC = 8'h17;
	localparam logic [7:0] PMTC_SRC_HF_DIV32 = 8'h18;
	// per-slot groups: upper nibble selects the group
	localparam logic [3:0] PMTC_GRP_ACTIVE = 4'h2;
	localparam logic [3:0] PMTC_GRP_LED = 4'h3;
	localparam logic [3:0] PMTC_GRP_MOD = 4'h4;
	localparam logic [3:0] PMTC_GRP_DATA = 4'h5;
	localparam logic [3:0] PMTC_IDX_ANY = 4'hF;
	localparam logic [3:0] PMTC_LED_IDX_BASE = 4'h1;

	// divider taps on the counter of 32 MHz edges
	localparam int PMTC_DIV_W = 6;
	localparam int PMTC_TAP_DIV32 = 4;
	localparam int PMTC_TAP_DIV64 = 5;

endpackage

// file: src/pmtc_src_mux.sv
// pmtc_src_mux: picks the level a pin presents from its source code
`timescale 1ns/10ps
module pmtc_src_mux
	import pmtc_pkg::*;
#(
	parameter int NUM_SLOTS = 12
) (
	input wire logic [7:0] i_sel,
	input wire logic i_int_x,
	input wire logic i_int_y,
	input wire logic i_led1_amp,
	input wire logic i_led2_amp,
	input wire logic i_osc_lf,
	input wire logic i_osc_hf,
	input wire logic i_hf_div32,
	input wire logic i_hf_div64,
	input wire logic i_sleep_level,
	input wire logic [NUM_SLOTS-1:0] i_slot_active,
	input wire logic [NUM_SLOTS-1:0] i_slot_level,
	input wire logic [NUM_SLOTS-1:0] i_slot_led,
	input wire logic [NUM_SLOTS-1:0] i_slot_mod,
	input wire logic [NUM_SLOTS-1:0] i_slot_data,
	output logic o_level
);
	logic [3:0] idx;
	logic idx_ok;
	logic [3:0] led_idx;
	logic led_ok;

	assign idx = i_sel[3:0];
	assign idx_ok = (32'(idx) < NUM_SLOTS);
	// led codes start one above the group base
	assign led_idx = idx - PMTC_LED_IDX_BASE;
	assign led_ok = (idx != 4'h0) && (32'(led_idx) < NUM_SLOTS);

	// unlisted codes fall to a quiet low
	always_comb begin
		o_level = 1'b0;
		unique case (i_sel[7:4])
			PMTC_GRP_ACTIVE: begin
				if (idx_ok) o_level = i_slot_active[idx]; // [RQ6]
			end
			PMTC_GRP_LED: begin
				if (idx == PMTC_IDX_ANY) begin
					o_level = |(i_slot_led & i_slot_active); // [RQ7]
				end else if (led_ok) begin
					o_level = i_slot_led[led_idx]; // [RQ7]
				end
			end
			PMTC_GRP_MOD: begin
				if (idx == PMTC_IDX_ANY) begin
					o_level = |(i_slot_mod & i_slot_active); // [RQ8]
				end else if (idx_ok) begin
					o_level = i_slot_mod[idx]; // [RQ8]
				end
			end
			PMTC_GRP_DATA: begin
				if (idx == PMTC_IDX_ANY) begin
					o_level = |i_slot_data; // [RQ9]
				end else if (idx_ok) begin
					o_level = i_slot_data[idx]; // [RQ9]
				end
			end
			default: begin
				case (i_sel)
					PMTC_SRC_LOW: o_level = 1'b0; // [RQ2]
					PMTC_SRC_HIGH: o_level = 1'b1; // [RQ2]
					PMTC_SRC_INT_X: o_level = i_int_x; // [RQ2]
					PMTC_SRC_INT_Y: o_level = i_int_y; // [RQ2]
					PMTC_SRC_LED1_AMP: o_level = i_led1_amp; // [RQ3]
					PMTC_SRC_LED2_AMP: o_level = i_led2_amp; // [RQ3]
					PMTC_SRC_ANY_AMP: o_level = i_led1_amp | i_led2_amp; // [RQ3]
					PMTC_SRC_HF_DIV64: o_level = i_hf_div64; // [RQ4]
					PMTC_SRC_LF_OSC: o_level = i_osc_lf; // [RQ4]
					PMTC_SRC_HF_OSC: o_level = i_osc_hf; // [RQ4]
					PMTC_SRC_HF_DIV32: o_level = i_hf_div32; // [RQ4]
					PMTC_SRC_PATTERN: begin
						// sleep level only while no slot runs
						if (|i_slot_active) begin
							o_level = |(i_slot_active & i_slot_level); // [RQ5]
						end else begin
							o_level = i_sleep_level; // [RQ5] [RQ12]
						end
					end
					default: o_level = 1'b0;
				endcase
			end
		endcase
	end
endmodule

// file: src/pmtc_top.sv
// pmtc_top: two-pin mux, input readback and time stamp capture
`timescale 1ns/10ps
// How it works
// RQ1: each pin has a 3-bit electrical mode
// RQ2: codes 0-3 give low, high, chan X, Y
// RQ3: codes 08/09/0C give LED amplifier enables
// RQ4: codes 0F/16/17/18 give oscillator outputs
// RQ5: code 10 gives per-slot pattern, sleep otherwise
// RQ6: codes 20-2B follow slot A-L active
// RQ7: codes 31-3C slot LED pulse, 3F any
// RQ8: codes 40-4B slot modulation pulse, 4F any
// RQ9: codes 50-5B slot data cycle, 5F any
// RQ10: second pin has same code set, own field
// RQ11: readback shows inputs of enabled buffers
// RQ12: one bit holds pattern level during sleep
// RQ13: edge invert picks rising or falling capture
// RQ14: always-armed keeps arm set after capture
// RQ15: 2-bit selector picks stamp pin 0 or 1
// RQ16: capture latches timer into low/high halves
// RQ17: capture latches counts remaining until wake
// RQ18: three enables gate FIFO statuses onto X
// RQ19: three separate enables gate statuses onto Y
// RQ20: arm makes next edge capture, then clears
// RQ21: each channel is OR of enabled statuses
module pmtc_top
	import pmtc_pkg::*;
#(
	parameter int NUM_SLOTS = 12,
	parameter int NUM_PINS = 2
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [8:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] i_reg_wdata,
	output logic [15:0] o_reg_rdata,
	output logic o_reg_rvalid,
	input wire logic [NUM_PINS-1:0] i_pin_in,
	output logic [NUM_PINS-1:0] o_pin_out,
	output logic [NUM_PINS-1:0] o_pin_oe,
	output logic [NUM_PINS-1:0] o_pin_pull_up,
	output logic [NUM_PINS-1:0] o_pin_pull_dn,
	output logic [NUM_PINS-1:0] o_pin_in_en,
	output logic [1:0] o_pin_slew,
	output logic [1:0] o_pin_drive,
	output logic o_int_x,
	output logic o_int_y,
	input wire logic i_fifo_threshold,
	input wire logic i_fifo_underflow,
	input wire logic i_fifo_overflow,
	input wire logic i_led1_amp,
	input wire logic i_led2_amp,
	input wire logic i_osc_lf,
	input wire logic i_osc_hf,
	input wire logic [NUM_SLOTS-1:0] i_slot_active,
	input wire logic [NUM_SLOTS-1:0] i_slot_level,
	input wire logic [NUM_SLOTS-1:0] i_slot_led,
	input wire logic [NUM_SLOTS-1:0] i_slot_mod,
	input wire logic [NUM_SLOTS-1:0] i_slot_data,
	input wire logic [31:0] i_timer_count,
	input wire logic [15:0] i_wake_remaining
);
	typedef struct packed {
		logic [2:0] x_en;
		logic [2:0] y_en;
		logic [2:0] mode0;
		logic [2:0] mode1;
		logic [1:0] slew;
		logic [1:0] drive;
		logic [7:0] sel0;
		logic [7:0] sel1;
		logic sleep_level;
		logic edge_inv;
		logic always_armed;
		logic [1:0] pin_sel;
		logic arm;
		logic [15:0] cnt_lo;
		logic [15:0] cnt_hi;
		logic [15:0] remain;
		logic [1:0] pin_in;
		logic trig_prev;
		logic int_x;
		logic int_y;
		logic hf_prev;
		logic [PMTC_DIV_W-1:0] div;
		logic [NUM_PINS-1:0] pin_out;
		logic [NUM_PINS-1:0] pin_oe;
		logic [NUM_PINS-1:0] pull_up;
		logic [NUM_PINS-1:0] pull_dn;
		logic [NUM_PINS-1:0] in_en;
		logic [15:0] rdata;
		logic rvalid;
	} pmtc_state_t;

	pmtc_state_t st_q;
	pmtc_state_t st_d;
	logic [NUM_PINS-1:0] src_level;
	logic [2:0] fifo_stat;
	logic [NUM_PINS-1:0] gated_in;
	logic trig_now;
	logic trig_valid;
	logic trig_edge;
	logic capture;
	logic wr_arm;
	logic sw_reset;

	// one mux per pin; both pins share one code set
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
			pmtc_src_mux #(
				.NUM_SLOTS(NUM_SLOTS)
			) u_mux (
				.i_sel((gp == 0) ? st_q.sel0 : st_q.sel1), // [RQ10]
				.i_int_x(st_q.int_x),
				.i_int_y(st_q.int_y),
				.i_led1_amp(i_led1_amp),
				.i_led2_amp(i_led2_amp),
				.i_osc_lf(i_osc_lf),
				.i_osc_hf(i_osc_hf),
				.i_hf_div32(st_q.div[PMTC_TAP_DIV32]),
				.i_hf_div64(st_q.div[PMTC_TAP_DIV64]),
				.i_sleep_level(st_q.sleep_level),
				.i_slot_active(i_slot_active),
				.i_slot_level(i_slot_level),
				.i_slot_led(i_slot_led),
				.i_slot_mod(i_slot_mod),
				.i_slot_data(i_slot_data),
				.o_level(src_level[gp])
			);
			// every mode except off keeps the input buffer on
			assign gated_in[gp] = i_pin_in[gp] & st_q.in_en[gp]; // [RQ11]
		end
	endgenerate

	// capture source and edge; reserved selector codes never fire
	assign fifo_stat = {i_fifo_threshold, i_fifo_underflow, i_fifo_overflow};
	assign trig_valid = (st_q.pin_sel == PMTC_STAMP_PIN0) ||
		(st_q.pin_sel == PMTC_STAMP_PIN1); // [RQ15]
	assign trig_now = (st_q.pin_sel == PMTC_STAMP_PIN1) ? gated_in[1] :
		gated_in[0]; // [RQ15]
	assign trig_edge = st_q.edge_inv ? (st_q.trig_prev & ~trig_now) :
		(~st_q.trig_prev & trig_now); // [RQ13]
	assign capture = st_q.arm & trig_valid & trig_edge; // [RQ20]
	assign wr_arm = i_reg_wr && (i_reg_addr == PMTC_OFS_ARM);
	assign sw_reset = i_reg_wr && (i_reg_addr == PMTC_OFS_SYS) &&
		i_reg_wdata[PMTC_BIT_SW_RESET];

	// next state of the whole block
	always_comb begin
		st_d = st_q;
		st_d.rvalid = i_reg_rd;
		st_d.pin_in = gated_in; // [RQ11]
		st_d.trig_prev = trig_now;
		// divider advances on each rising 32 MHz sample
		st_d.hf_prev = i_osc_hf;
		if (i_osc_hf && !st_q.hf_prev) begin
			st_d.div = st_q.div + PMTC_DIV_W'(1); // [RQ4]
		end
		st_d.int_x = |(fifo_stat & st_q.x_en); // [RQ18] [RQ21]
		st_d.int_y = |(fifo_stat & st_q.y_en); // [RQ19] [RQ21]

		// capture: counts latched, arm dropped unless always armed
		if (capture) begin
			st_d.cnt_lo = i_timer_count[15:0]; // [RQ16]
			st_d.cnt_hi = i_timer_count[31:16]; // [RQ16]
			st_d.remain = i_wake_remaining; // [RQ17]
			if (!st_q.always_armed) begin
				st_d.arm = 1'b0; // [RQ20]
			end else begin
				st_d.arm = 1'b1; // [RQ14]
			end
		end

		// register writes; a software write to arm beats the clear
		if (i_reg_wr) begin
			unique case (i_reg_addr)
				PMTC_OFS_ARM: st_d.arm = i_reg_wdata[PMTC_BIT_ARM]; // [RQ20]
				PMTC_OFS_IRQ_X: begin
					st_d.x_en = i_reg_wdata[PMTC_BIT_EN_OFLOW+:3]; // [RQ18]
				end
				PMTC_OFS_IRQ_Y: begin
					st_d.y_en = i_reg_wdata[PMTC_BIT_EN_OFLOW+:3]; // [RQ19]
				end
				PMTC_OFS_PIN_CFG: begin
					st_d.slew = i_reg_wdata[PMTC_BIT_SLEW_LO+:2];
					st_d.drive = i_reg_wdata[PMTC_BIT_DRV_LO+:2];
					st_d.mode1 = i_reg_wdata[PMTC_BIT_MODE1_LO+:3]; // [RQ1]
					st_d.mode0 = i_reg_wdata[PMTC_BIT_MODE0_LO+:3]; // [RQ1]
				end
				PMTC_OFS_PIN_SEL: begin
					st_d.sel1 = i_reg_wdata[PMTC_BIT_SEL1_LO+:8]; // [RQ10]
					st_d.sel0 = i_reg_wdata[PMTC_BIT_SEL0_LO+:8];
				end
				PMTC_OFS_STAMP_CTL: begin
					st_d.sleep_level = i_reg_wdata[PMTC_BIT_SLEEP_LVL]; // [RQ12]
					st_d.edge_inv = i_reg_wdata[PMTC_BIT_EDGE_INV]; // [RQ13]
					st_d.always_armed = i_reg_wdata[PMTC_BIT_ALWAYS]; // [RQ14]
					st_d.pin_sel = i_reg_wdata[PMTC_BIT_PIN_SEL_LO+:2]; // [RQ15]
				end
				default: begin
				end
			endcase
		end

		// read data is registered so the port comes from a flop
		st_d.rdata = PMTC_RST_REG;
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				PMTC_OFS_ARM: st_d.rdata[PMTC_BIT_ARM] = st_q.arm;
				PMTC_OFS_STAMP_LO: st_d.rdata = st_q.cnt_lo; // [RQ16]
				PMTC_OFS_STAMP_HI: st_d.rdata = st_q.cnt_hi; // [RQ16]
				PMTC_OFS_WAKE_REM: st_d.rdata = st_q.remain; // [RQ17]
				PMTC_OFS_IRQ_X: begin
					st_d.rdata[PMTC_BIT_EN_OFLOW+:3] = st_q.x_en;
				end
				PMTC_OFS_IRQ_Y: begin
					st_d.rdata[PMTC_BIT_EN_OFLOW+:3] = st_q.y_en;
				end
				PMTC_OFS_PIN_CFG: begin
					st_d.rdata[PMTC_BIT_SLEW_LO+:2] = st_q.slew;
					st_d.rdata[PMTC_BIT_DRV_LO+:2] = st_q.drive;
					st_d.rdata[PMTC_BIT_MODE1_LO+:3] = st_q.mode1;
					st_d.rdata[PMTC_BIT_MODE0_LO+:3] = st_q.mode0;
				end
				PMTC_OFS_PIN_SEL: st_d.rdata = {st_q.sel1, st_q.sel0};
				PMTC_OFS_PIN_IN: st_d.rdata[1:0] = st_q.pin_in; // [RQ11]
				PMTC_OFS_STAMP_CTL: begin
					st_d.rdata[PMTC_BIT_SLEEP_LVL] = st_q.sleep_level;
					st_d.rdata[PMTC_BIT_EDGE_INV] = st_q.edge_inv;
					st_d.rdata[PMTC_BIT_ALWAYS] = st_q.always_armed;
					st_d.rdata[PMTC_BIT_PIN_SEL_LO+:2] = st_q.pin_sel;
				end
				default: begin
				end
			endcase
		end

		// pin drivers from mode and source level
		for (int p = 0; p < NUM_PINS; p++) begin
			st_d.in_en[p] = (p == 0) ? (st_q.mode0 != PMTC_MODE_OFF) :
				(st_q.mode1 != PMTC_MODE_OFF);
			st_d.pin_out[p] = 1'b0;
			st_d.pin_oe[p] = 1'b0;
			st_d.pull_up[p] = 1'b0;
			st_d.pull_dn[p] = 1'b0;
			unique case (pmtc_mode_t'((p == 0) ? st_q.mode0 : st_q.mode1))
				PMTC_MODE_OFF, PMTC_MODE_INPUT: begin
				end
				PMTC_MODE_OUT: begin
					st_d.pin_out[p] = src_level[p]; // [RQ1]
					st_d.pin_oe[p] = 1'b1;
				end
				PMTC_MODE_OUT_INV: begin
					st_d.pin_out[p] = ~src_level[p]; // [RQ1]
					st_d.pin_oe[p] = 1'b1;
				end
				// pull-only modes drive one level, release to the pull
				PMTC_MODE_PD: begin
					st_d.pin_oe[p] = ~src_level[p]; // [RQ1]
					st_d.pull_dn[p] = 1'b1;
				end
				PMTC_MODE_PD_INV: begin
					st_d.pin_oe[p] = src_level[p]; // [RQ1]
					st_d.pull_dn[p] = 1'b1;
				end
				PMTC_MODE_PU: begin
					st_d.pin_out[p] = 1'b1;
					st_d.pin_oe[p] = src_level[p]; // [RQ1]
					st_d.pull_up[p] = 1'b1;
				end
				PMTC_MODE_PU_INV: begin
					st_d.pin_out[p] = 1'b1;
					st_d.pin_oe[p] = ~src_level[p]; // [RQ1]
					st_d.pull_up[p] = 1'b1;
				end
			endcase
		end

		// software reset returns everything to defaults
		if (sw_reset) begin
			st_d = '0;
		end
	end

	// the single state register
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_reg_rdata = st_q.rdata;
	assign o_reg_rvalid = st_q.rvalid;
	assign o_pin_out = st_q.pin_out;
	assign o_pin_oe = st_q.pin_oe;
	assign o_pin_pull_up = st_q.pull_up;
	assign o_pin_pull_dn = st_q.pull_dn;
	assign o_pin_in_en = st_q.in_en;
	assign o_pin_slew = st_q.slew;
	assign o_pin_drive = st_q.drive;
	assign o_int_x = st_q.int_x;
	assign o_int_y = st_q.int_y;

	// checks on the design's own behaviour
	a_arm_clears: assert property ( // [RQ20]
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		capture && !st_q.always_armed && !wr_arm && !sw_reset |=> !st_q.arm)
		else $error("arm bit stayed set after a one-shot capture");
	a_always_keeps: assert property ( // [RQ14]
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		capture && st_q.always_armed && !wr_arm && !sw_reset |=> st_q.arm)
		else $error("arm bit dropped while always armed");
	a_stamp_latch: assert property ( // [RQ16]
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		capture && !sw_reset
		|=> {st_q.cnt_hi, st_q.cnt_lo} == $past(i_timer_count))
		else $error("stamp halves do not hold the timer count");
	a_remain_latch: assert property ( // [RQ17]
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		capture && !sw_reset |=> st_q.remain == $past(i_wake_remaining))
		else $error("remaining count not latched at capture");
	a_no_edge_hold: assert property ( // [RQ13]
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		!capture && !sw_reset |=> $stable(st_q.cnt_lo))
		else $error("stamp changed without a qualifying edge");
	a_chan_x_or: assert property ( // [RQ18]
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		!sw_reset |=> o_int_x == |($past(fifo_stat) & $past(st_q.x_en)))
		else $error("channel X is not the OR of enabled statuses");
	a_chan_y_or: assert property ( // [RQ19]
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		!sw_reset |=> o_int_y == |($past(fifo_stat) & $past(st_q.y_en)))
		else $error("channel Y is not the OR of enabled statuses");
	a_readback_gate: assert property ( // [RQ11]
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		st_q.mode0 == PMTC_MODE_OFF && !sw_reset ##1 !sw_reset
		|=> !st_q.pin_in[0])
		else $error("disabled pin shows in readback");
	a_off_no_drive: assert property ( // [RQ1]
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		st_q.mode1 == PMTC_MODE_OFF |=> !o_pin_oe[1])
		else $error("pin driven while disabled");
	a_high_source: assert property ( // [RQ2]
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		st_q.mode0 == PMTC_MODE_OUT && st_q.sel0 == PMTC_SRC_HIGH && !sw_reset
		|=> o_pin_out[0] && o_pin_oe[0])
		else $error("constant high source not driven");
endmodule
